/* logic/crb_consts.svh */
`ifndef CRB_CONSTS_SVH
`define CRB_CONSTS_SVH
// Function
// - Inputs captured on rising clock edge; outputs hold otherwise.
// - Reset high clears registers and forces all outputs low.
// - Both chip selects high freeze gated bits; either low lets them update.
// - Clock-enable, termination and chip-select bits always capture their inputs.
// - Unused inputs ignored as standby; unused outputs always driven low.
// - One-to-one mode gates inputs 2,3,5,6 and 8 through 25.
// - One-to-two variant A gates inputs 2,3,5,6 and 8 through 14.
// - One-to-two variant B gates inputs 1-6, 8-10, 12, 13.
// - Variant B: chip select on 7, termination on 11, clock-enable on 14.
// - Reset has priority over chip-select gating.

// ****************************************
// Widths and bit positions (1-based positions mapped to index-1)
// ****************************************
`define CRB_WIDTH 25
`define CRB_HALF 14
`define CRB_IDX_CKE_A 0
`define CRB_IDX_ODT_A 3
`define CRB_IDX_CS 6
`define CRB_IDX_ODT_B 10
`define CRB_IDX_CKE_B 13
// Ungated bits per mode, as masks over the 25 positions
`define CRB_UNGATED_1TO1 25'h0000049
`define CRB_UNGATED_A 25'h0000049
`define CRB_UNGATED_B 25'h0002440
// Active positions per mode
`define CRB_ACTIVE_1TO1 25'h1FFFFFF
`define CRB_ACTIVE_HALF 25'h0003FFF
`define CRB_ZERO 25'h0000000
`endif

/* logic/crb_pkg.sv */
package crb_pkg;
	typedef enum logic [1:0] {
		CRB_ONE_TO_ONE = 2'h0,
		CRB_RSVD = 2'h1,
		CRB_VARIANT_A = 2'h2,
		CRB_VARIANT_B = 2'h3
	} crb_mode_t;
	typedef struct packed {
		logic [24:0] a;
		logic [24:0] b;
	} crb_out_t;
endpackage

/* logic/crb_mode_decode.sv */
`timescale 1ns/100ps
`include "crb_consts.svh"
module crb_mode_decode (
	input wire logic variant_select,
	input wire logic fanout_select,
	output crb_pkg::crb_mode_t mode,
	output logic [24:0] active_mask,
	output logic [24:0] gated_mask
);
	// ****************************************
	// Configuration decode
	// ****************************************
	// Second select picks fan-out, first picks variant
	always_comb begin
		mode = crb_pkg::crb_mode_t'({fanout_select, variant_select});
		case (mode)
			crb_pkg::CRB_VARIANT_A: begin
				active_mask = `CRB_ACTIVE_HALF;
				gated_mask = `CRB_ACTIVE_HALF & ~`CRB_UNGATED_A;
			end
			crb_pkg::CRB_VARIANT_B: begin
				active_mask = `CRB_ACTIVE_HALF;
				gated_mask = `CRB_ACTIVE_HALF & ~`CRB_UNGATED_B;
			end
			crb_pkg::CRB_ONE_TO_ONE: begin
				active_mask = `CRB_ACTIVE_1TO1;
				gated_mask = `CRB_ACTIVE_1TO1 & ~`CRB_UNGATED_1TO1;
			end
			default: begin
				// Variant select with one-to-one is unlisted; treat as one-to-one
				active_mask = `CRB_ACTIVE_1TO1;
				gated_mask = `CRB_ACTIVE_1TO1 & ~`CRB_UNGATED_1TO1;
			end
		endcase
	end
endmodule

/* logic/crb_buffer.sv */
`timescale 1ns/100ps
`include "crb_consts.svh"
module crb_buffer (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic VARIANT_SELECT,
	input wire logic FANOUT_SELECT,
	input wire logic SECONDARY_CHIP_SELECT_IN_N,
	input wire logic [24:0] BUFFER_INPUT_BIT,
	output logic [24:0] BUFFER_OUTPUT_BIT_A,
	output logic [24:0] BUFFER_OUTPUT_BIT_B
);
	crb_pkg::crb_mode_t mode;
	logic [24:0] active_mask;
	logic [24:0] gated_mask;
	logic [24:0] ungated_mask;
	logic freeze;
	logic fanout2;
	logic [24:0] data_d;
	crb_pkg::crb_out_t out_d;
	crb_pkg::crb_out_t out_q;

	// ****************************************
	// Mode decode
	// ****************************************
	crb_mode_decode u_dec (
		.variant_select(VARIANT_SELECT),
		.fanout_select(FANOUT_SELECT),
		.mode(mode),
		.active_mask(active_mask),
		.gated_mask(gated_mask)
	);

	// Primary chip select sits on position 7 in every mode
	assign freeze = BUFFER_INPUT_BIT[`CRB_IDX_CS] & SECONDARY_CHIP_SELECT_IN_N;
	assign fanout2 = (mode == crb_pkg::CRB_VARIANT_A) || (mode == crb_pkg::CRB_VARIANT_B);
	assign ungated_mask = active_mask & ~gated_mask;

	// ****************************************
	// Next value
	// ****************************************
	// Ungated bits always load; gated bits hold while frozen; unused stay low
	always_comb begin
		data_d = (BUFFER_INPUT_BIT & ungated_mask)
			| ((freeze ? out_q.a : BUFFER_INPUT_BIT) & gated_mask);
		data_d = data_d & active_mask;
		out_d.a = data_d;
		out_d.b = fanout2 ? data_d : `CRB_ZERO;
	end

	// ****************************************
	// Output register
	// ****************************************
	// Reset wins over gating and loads zeros on the edge
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			out_q <= '0;
		end else begin
			out_q <= out_d;
		end
	end

	assign BUFFER_OUTPUT_BIT_A = out_q.a;
	assign BUFFER_OUTPUT_BIT_B = out_q.b;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);

	a_reset_clears_outputs: assert property (disable iff (1'b0)
		RST |=> (BUFFER_OUTPUT_BIT_A == '0) && (BUFFER_OUTPUT_BIT_B == '0))
		else $error("outputs not low after reset");
	a_frozen_bits_hold: assert property (
		freeze |=> ((BUFFER_OUTPUT_BIT_A & $past(gated_mask))
			== ($past(BUFFER_OUTPUT_BIT_A) & $past(gated_mask))))
		else $error("gated bits changed while frozen");
	a_open_bits_follow: assert property (
		!freeze |=> ((BUFFER_OUTPUT_BIT_A & $past(gated_mask))
			== ($past(BUFFER_INPUT_BIT) & $past(gated_mask))))
		else $error("gated bits did not follow input");
	a_control_bits_pass: assert property (
		1'b1 |=> ((BUFFER_OUTPUT_BIT_A & $past(ungated_mask))
			== ($past(BUFFER_INPUT_BIT) & $past(ungated_mask))))
		else $error("control bit not captured");
	a_unused_low: assert property (
		1'b1 |=> ((BUFFER_OUTPUT_BIT_A & ~$past(active_mask)) == '0))
		else $error("unused output not low");
	a_copies_match: assert property (
		fanout2 |=> (BUFFER_OUTPUT_BIT_B == BUFFER_OUTPUT_BIT_A))
		else $error("B copy differs from A");
	a_single_copy_low: assert property (
		!fanout2 |=> (BUFFER_OUTPUT_BIT_B == '0))
		else $error("B copy driven in one-to-one");
	a_variant_b_map: assert property (
		(mode == crb_pkg::CRB_VARIANT_B) |=>
			(BUFFER_OUTPUT_BIT_A[`CRB_IDX_CKE_B] == $past(BUFFER_INPUT_BIT[`CRB_IDX_CKE_B]))
			&& (BUFFER_OUTPUT_BIT_A[`CRB_IDX_ODT_B] == $past(BUFFER_INPUT_BIT[`CRB_IDX_ODT_B])))
		else $error("variant B control bits gated");
	a_gate_sets: assert property (
		(mode == crb_pkg::CRB_ONE_TO_ONE) |-> (gated_mask == 25'h1FFFFB6))
		else $error("one-to-one gate set wrong");

	c_frozen: cover property (freeze ##1 freeze);
	c_variant_a: cover property (mode == crb_pkg::CRB_VARIANT_A && !freeze);
	c_variant_b: cover property (mode == crb_pkg::CRB_VARIANT_B && freeze);
	c_reset_exit: cover property (disable iff (1'b0) RST ##1 !RST);
endmodule

/* verif/crb_ctrl_model.sv */
`timescale 1ns/100ps
module crb_ctrl_model (
	input wire logic clock,
	input wire logic rst_req,
	input wire logic [1:0] cfg_req,
	output logic rst,
	output logic [1:0] cfg
);
	// Selects move only under reset, since a live change would remap the control and unused bits
	always_ff @(posedge clock) begin
		if (rst_req) begin
			cfg <= cfg_req;
		end
	end
	// Reset is held from time zero until the clock is stable
	assign rst = rst_req;
endmodule

/* verif/crb_buffer_tb.sv */
`timescale 1ns/100ps
module crb_buffer_tb;
	logic clock = 1'h0;
	logic rst_req = 1'h1;
	logic [1:0] cfg_req = 2'h0;
	logic rst;
	logic [1:0] cfg;
	logic [25:0] cmd = 26'h0;
	logic [25:0] pcmd = 26'h0;
	logic prst = 1'h1;
	logic [31:0] seed = 32'h25;
	int m;
	int n_errors = 0;
	int checked = 0;
	logic [24:0] got_a;
	logic [24:0] got_b;
	crb_pkg::crb_out_t exp_q = '0;
	// ****************
	// Clock and instances
	// ****************
	initial begin
		forever #5 clock = ~clock;
	end
	crb_ctrl_model i_ctrl (.clock(clock), .rst_req(rst_req), .cfg_req(cfg_req), .rst(rst),
		.cfg(cfg));
	crb_buffer i_dut (.CLOCK(clock), .RST(rst), .VARIANT_SELECT(cfg[0]),
		.FANOUT_SELECT(cfg[1]), .SECONDARY_CHIP_SELECT_IN_N(cmd[25]),
		.BUFFER_INPUT_BIT(cmd[24:0]), .BUFFER_OUTPUT_BIT_A(got_a), .BUFFER_OUTPUT_BIT_B(got_b));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Next outputs; a freeze keeps gated bits but still loads the ungated ones
	function automatic crb_pkg::crb_out_t nxt(input crb_pkg::crb_out_t e,
		input logic [25:0] v, input logic [1:0] md);
		logic [24:0] act;
		logic [24:0] ung;
		logic [24:0] a;
		act = md[1] ? 25'h0003FFF : 25'h1FFFFFF;
		ung = (md == 2'h3) ? 25'h0002440 : 25'h0000049;
		a = (v[6] & v[25]) ? ((e.a & ~ung) | (v[24:0] & ung)) : v[24:0];
		nxt.a = a & act;
		nxt.b = md[1] ? (a & act) : 25'h0000000;
	endfunction
	task automatic check(input crb_pkg::crb_out_t seen, input crb_pkg::crb_out_t want);
		checked++;
		if (seen !== want) begin
			n_errors++;
			$display("Error at %0t: outputs %h expected %h", $time, seen, want);
		end
	endtask
	// One edge: the value sent last edge is judged now, as the design samples it here
	task automatic step(input logic r, input logic [25:0] v);
		@(posedge clock);
		rst_req <= r;
		cmd <= v;
		#1;
		exp_q = prst ? '0 : nxt(exp_q, pcmd, cfg_req);
		check(crb_pkg::crb_out_t'({got_a, got_b}), exp_q);
		prst = r;
		pcmd = v;
	endtask
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ****************
	// Main sequence: each mode behind its own reset
	// ****************
	initial begin
		// The unlisted select pair is run too, since the design decodes it as one-to-one
		for (int k = 0; k < 4; k++) begin
			m = k;
			for (int i = 0; i < 20; i++) begin
				seed = lfsr(seed);
				step(1'h1, seed[25:0]);
				cfg_req = 2'(m);
			end
			for (int i = 0; i < 80; i++) begin
				seed = lfsr(seed);
				step(1'h0, seed[25:0]);
			end
			step(1'h0, 26'h3FFFFFF);
			step(1'h0, 26'h2000040);
			step(1'h0, 26'h0000000);
			step(1'h0, 26'h0000000);
			$display("Mode %0d done", m);
		end
		end_of_test();
	end
endmodule
